// ===== rtl/strap_option_latch.sv
// Function
// [RL1] Code 100 is MII100 preamble restore; 101-111 reserved.
// [RL2] Isolate strap lands in control bit 10.
// [RL3] Speed strap lands in control bit 13.
// [RL4] Speed strap also sets advertised speed capabilities.
// [RL5] Duplex strap lands in control bit 8.
// [RL6] Auto-negotiation strap high enables, low disables.
// [RL7] Strap pins input during reset, outputs afterwards.
// [RL8] Code 000 is MII, 001 RMII; 010-011 reserved.
// [RL9] Station address from three straps, bits 4:3 zero.
// [RL10] Capture at reset release; software may override later.
module strap_option_latch (
	input wire logic sys_clk,
	input wire logic rstn,
	input strap_pkg::strap_t strap_in,
	output strap_pkg::strap_t strap_out,
	output strap_pkg::strap_t strap_oe,
	input strap_pkg::strap_t func_out,
	input strap_pkg::wb_req_t wb_req,
	output logic wb_ack,
	output logic [31:0] wb_dat_o,
	output logic speed_100,
	output logic duplex_half,
	output logic isolate,
	output logic autoneg_enable,
	output logic [3:0] adv_caps,
	output strap_pkg::iface_mode_t iface_mode,
	output logic mode_reserved,
	output logic [4:0] station_address,
	output logic straps_latched
);

	strap_pkg::strap_t strap_sync_w;  // Pin levels after two flops.
	strap_pkg::strap_t captured_q;    // Raw levels seen at reset release.
	strap_pkg::phase_t phase_q;       // Sample phase, then normal run.
	strap_pkg::iface_mode_t mode_d;   // Mode decoded from synchronised straps.
	logic mode_rsvd_d;                // Reserved code seen on the pins.
	logic ack_q;                      // One-cycle Wishbone acknowledge.
	logic [31:0] rdata_q;             // Registered read data.
	logic [31:0] rdata_d;             // Read data for the current address.
	logic bus_req;                    // A new request not yet acknowledged.
	logic wr_ctrl;                    // Accepted write to the control word.
	logic wr_adv;                     // Accepted write to the advertisement word.

	// The pins are read only after two flops, as they come from the board.
	strap_sync #(
		.WIDTH($bits(strap_pkg::strap_t))
	) u_sync (
		.sys_clk(sys_clk),
		.async_in(strap_in),
		.sync_out(strap_sync_w)
	);

	// Decode the interface-select code into a mode.
	always_comb begin
		mode_d = strap_pkg::MODE_RESERVED; // [RL1] [RL8]
		mode_rsvd_d = 1'b1;
		case (strap_sync_w.iface_sel)
			strap_pkg::IFSEL_MII: begin
				mode_d = strap_pkg::MODE_MII; // [RL8]
				mode_rsvd_d = 1'b0;
			end
			strap_pkg::IFSEL_RMII: begin
				mode_d = strap_pkg::MODE_RMII; // [RL8]
				mode_rsvd_d = 1'b0;
			end
			strap_pkg::IFSEL_MII100_PRE: begin
				mode_d = strap_pkg::MODE_MII100_PRE; // [RL1]
				mode_rsvd_d = 1'b0;
			end
			default: begin
				// Reserved codes decode to the reserved mode and raise the flag,
				// so software sees the misstrap instead of a guessed mode.
				mode_d = strap_pkg::MODE_RESERVED; // [RL1] [RL8]
				mode_rsvd_d = 1'b1;
			end
		endcase
	end

	// Phase: the first edge after release captures, then the block runs.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			phase_q <= strap_pkg::PH_SAMPLE;
		end else begin
			case (phase_q)
				strap_pkg::PH_SAMPLE: phase_q <= strap_pkg::PH_RUN; // [RL10]
				strap_pkg::PH_RUN: phase_q <= strap_pkg::PH_RUN;
				default: phase_q <= strap_pkg::PH_SAMPLE;
			endcase
		end
	end

	assign straps_latched = (phase_q == strap_pkg::PH_RUN);

	// Raw strap capture; it never changes again until the next reset.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			captured_q <= strap_pkg::STRAP_DEFAULT;
			iface_mode <= strap_pkg::MODE_MII;
			mode_reserved <= 1'b0;
		end else if (phase_q == strap_pkg::PH_SAMPLE) begin
			captured_q <= strap_sync_w; // [RL10]
			iface_mode <= mode_d; // [RL1] [RL8]
			mode_reserved <= mode_rsvd_d; // [RL1]
		end
	end

	// Station address: three strap bits, the top two forced to zero.
	assign station_address = {strap_pkg::STATION_ADDR_HIGH, captured_q.addr}; // [RL9]

	// Pins stay inputs until the capture has been taken, which avoids
	// the device fighting the board pulls while they are being read.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			strap_oe <= '0; // [RL7]
			strap_out <= '0;
		end else begin
			strap_oe <= (phase_q == strap_pkg::PH_RUN) ? '1 : '0; // [RL7]
			strap_out <= func_out;
		end
	end

	// Wishbone decode; a request is acknowledged one cycle after it appears.
	assign bus_req = wb_req.cyc && wb_req.stb && !ack_q;
	assign wr_ctrl = bus_req && wb_req.we && (wb_req.adr == strap_pkg::ADDR_CTRL);
	assign wr_adv = bus_req && wb_req.we && (wb_req.adr == strap_pkg::ADDR_ADV);

	// Control settings: capture at release, software writes afterwards.
	// Writes are ignored in the capture cycle so the straps always win there.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			speed_100 <= strap_pkg::STRAP_DEFAULT.speed;
			duplex_half <= strap_pkg::STRAP_DEFAULT.duplex;
			isolate <= strap_pkg::STRAP_DEFAULT.isolate;
			autoneg_enable <= strap_pkg::STRAP_DEFAULT.autoneg;
		end else if (phase_q == strap_pkg::PH_SAMPLE) begin
			speed_100 <= strap_sync_w.speed; // [RL3]
			duplex_half <= strap_sync_w.duplex; // [RL5]
			isolate <= strap_sync_w.isolate; // [RL2]
			autoneg_enable <= strap_sync_w.autoneg; // [RL6]
		end else if (wr_ctrl && wb_req.sel[strap_pkg::CTRL_LANE]) begin
			speed_100 <= wb_req.dat[strap_pkg::CTRL_SPEED_BIT]; // [RL10]
			duplex_half <= wb_req.dat[strap_pkg::CTRL_DUPLEX_BIT];
			isolate <= wb_req.dat[strap_pkg::CTRL_ISO_BIT];
			autoneg_enable <= wb_req.dat[strap_pkg::CTRL_AUTONEG_BIT];
		end
	end

	// Advertised capabilities follow the speed strap; a 10 Mbps strap
	// drops both 100 Mbps abilities. Byte lanes split the field.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			adv_caps <= strap_pkg::ADV_CAPS_100;
		end else if (phase_q == strap_pkg::PH_SAMPLE) begin
			adv_caps <= strap_sync_w.speed ? strap_pkg::ADV_CAPS_100 : strap_pkg::ADV_CAPS_10; // [RL4]
		end else if (wr_adv) begin
			if (wb_req.sel[strap_pkg::ADV_HI_LANE]) begin
				adv_caps[3] <= wb_req.dat[strap_pkg::ADV_MSB]; // [RL10]
			end
			if (wb_req.sel[strap_pkg::ADV_LO_LANE]) begin
				adv_caps[2:0] <= wb_req.dat[strap_pkg::ADV_MSB-1:strap_pkg::ADV_LSB];
			end
		end
	end

	// Read mux; unmapped addresses read as zero and are still acknowledged.
	always_comb begin
		rdata_d = '0;
		case (wb_req.adr)
			strap_pkg::ADDR_CTRL: begin
				rdata_d[strap_pkg::CTRL_SPEED_BIT] = speed_100;
				rdata_d[strap_pkg::CTRL_AUTONEG_BIT] = autoneg_enable;
				rdata_d[strap_pkg::CTRL_ISO_BIT] = isolate;
				rdata_d[strap_pkg::CTRL_DUPLEX_BIT] = duplex_half;
			end
			strap_pkg::ADDR_ADV: begin
				rdata_d[strap_pkg::ADV_MSB:strap_pkg::ADV_LSB] = adv_caps;
			end
			strap_pkg::ADDR_STATUS: begin
				rdata_d[strap_pkg::STAT_ADDR_MSB:strap_pkg::STAT_ADDR_LSB] = station_address;
				rdata_d[strap_pkg::STAT_MODE_MSB:strap_pkg::STAT_MODE_LSB] = iface_mode;
				rdata_d[strap_pkg::STAT_RSVD_BIT] = mode_reserved;
				rdata_d[strap_pkg::STAT_RAW_MSB:strap_pkg::STAT_RAW_LSB] = captured_q;
				rdata_d[strap_pkg::STAT_DONE_BIT] = straps_latched;
			end
			default: begin
				rdata_d = '0;
			end
		endcase
	end

	// Acknowledge and read data; ack drops in the cycle after it was given.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ack_q <= 1'b0;
			rdata_q <= '0;
		end else begin
			ack_q <= bus_req;
			if (bus_req) begin
				rdata_q <= rdata_d;
			end
		end
	end

	assign wb_ack = ack_q;
	assign wb_dat_o = rdata_q;

	// Checks on the capture, decode, pin direction and bus acknowledge.
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	AST_MODE_100: assert property ($rose(straps_latched) && // [RL1]
		$past(strap_sync_w.iface_sel) == strap_pkg::IFSEL_MII100_PRE |->
		iface_mode == strap_pkg::MODE_MII100_PRE)
		else $error("code 100 did not decode to MII100 preamble restore");
	AST_MODE_RSVD: assert property ($rose(straps_latched) && // [RL1]
		$past(strap_sync_w.iface_sel[2]) && $past(strap_sync_w.iface_sel[1:0]) != 2'h0
		|-> mode_reserved)
		else $error("reserved high code not flagged");
	AST_ISO: assert property ($rose(straps_latched) |-> isolate == $past(strap_sync_w.isolate)) // [RL2]
		else $error("isolate strap not captured");
	AST_SPEED: assert property ($rose(straps_latched) |-> speed_100 == $past(strap_sync_w.speed)) // [RL3]
		else $error("speed strap not captured");
	AST_ADV: assert property ($rose(straps_latched) |-> adv_caps == // [RL4]
		($past(strap_sync_w.speed) ? strap_pkg::ADV_CAPS_100 : strap_pkg::ADV_CAPS_10))
		else $error("advertisement does not follow speed strap");
	AST_DUPLEX: assert property ($rose(straps_latched) |-> // [RL5]
		duplex_half == $past(strap_sync_w.duplex))
		else $error("duplex strap not captured");
	AST_AUTONEG: assert property ($rose(straps_latched) |-> // [RL6]
		autoneg_enable == $past(strap_sync_w.autoneg))
		else $error("auto-negotiation strap not captured");
	AST_PIN_DIR: assert property (straps_latched |=> strap_oe == '1 [*3]) // [RL7]
		else $error("strap pins not driven after capture");
	AST_PIN_IN: assert property (!straps_latched |-> strap_oe == '0) // [RL7]
		else $error("strap pin driven before capture");
	AST_MODE_LOW: assert property ($rose(straps_latched) |-> iface_mode == // [RL8]
		($past(strap_sync_w.iface_sel) == strap_pkg::IFSEL_MII ? strap_pkg::MODE_MII :
		$past(strap_sync_w.iface_sel) == strap_pkg::IFSEL_RMII ? strap_pkg::MODE_RMII :
		$past(strap_sync_w.iface_sel) == strap_pkg::IFSEL_MII100_PRE ?
		strap_pkg::MODE_MII100_PRE : strap_pkg::MODE_RESERVED))
		else $error("interface code decoded wrongly");
	// Compares against the pins seen at capture, not the register that feeds the output.
	AST_STATION: assert property ($rose(straps_latched) |-> // [RL9]
		station_address == {strap_pkg::STATION_ADDR_HIGH, $past(strap_sync_w.addr)})
		else $error("station address not formed from address straps");
	AST_HOLD: assert property (straps_latched |=> $stable(captured_q)) // [RL10]
		else $error("captured straps changed without reset");
	AST_ACK: assert property (bus_req |=> wb_ack ##1 !wb_ack) // [RL10]
		else $error("bus acknowledge not a single cycle");

	COV_RMII: cover property ($rose(straps_latched) && iface_mode == strap_pkg::MODE_RMII);
	COV_SPEED10: cover property ($rose(straps_latched) && !speed_100);
	COV_OVERRIDE: cover property (wr_ctrl && straps_latched);
	COV_RSVD: cover property ($rose(straps_latched) && mode_reserved);

endmodule

// ===== pkg/strap_pkg.sv
package strap_pkg;

	// Strap levels travel together; field order is the pin bundle order.
	typedef struct packed {
		logic autoneg;          // Auto-negotiation enable strap.
		logic duplex;           // High selects half duplex.
		logic speed;            // High selects 100 Mbps.
		logic isolate;          // High requests isolation.
		logic [2:0] iface_sel;  // Interface-select strap code.
		logic [2:0] addr;       // Low three station address bits.
	} strap_t;

	// Value the straps assume when no capture has happened yet.
	localparam strap_t STRAP_DEFAULT = '{autoneg: 1'b1, duplex: 1'b1, speed: 1'b1,
		isolate: 1'b0, iface_sel: 3'h0, addr: 3'h1};

	// Decoded interface mode.
	typedef enum logic [1:0] {
		MODE_MII = 2'b00,
		MODE_RMII = 2'b01,
		MODE_MII100_PRE = 2'b10,
		MODE_RESERVED = 2'b11
	} iface_mode_t;

	// Interface-select strap codes.
	localparam logic [2:0] IFSEL_MII = 3'h0;
	localparam logic [2:0] IFSEL_RMII = 3'h1;
	localparam logic [2:0] IFSEL_MII100_PRE = 3'h4;

	// Station address bits 4 and 3 are always zero.
	localparam logic [1:0] STATION_ADDR_HIGH = 2'h0;

	// Capture phase of the block.
	typedef enum logic {
		PH_SAMPLE = 1'b0,
		PH_RUN = 1'b1
	} phase_t;

	// Classic Wishbone request bundle from the master.
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [7:0] adr;
		logic [31:0] dat;
	} wb_req_t;

	// Register byte addresses.
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_ADV = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;

	// Control register bit positions.
	localparam int CTRL_SPEED_BIT = 13;
	localparam int CTRL_AUTONEG_BIT = 12;
	localparam int CTRL_ISO_BIT = 10;
	localparam int CTRL_DUPLEX_BIT = 8;
	localparam int CTRL_LANE = 1;

	// Advertisement field: bits 8..5 are 100FD, 100HD, 10FD, 10HD.
	localparam int ADV_LSB = 5;
	localparam int ADV_MSB = 8;
	localparam logic [3:0] ADV_CAPS_100 = 4'hf;
	localparam logic [3:0] ADV_CAPS_10 = 4'h3;
	// Byte lanes that carry the advertisement field: bit 8, then bits 7..5.
	localparam int ADV_HI_LANE = 1;
	localparam int ADV_LO_LANE = 0;

	// Status register field positions.
	localparam int STAT_ADDR_LSB = 0;
	localparam int STAT_ADDR_MSB = 4;
	localparam int STAT_MODE_LSB = 5;
	localparam int STAT_MODE_MSB = 6;
	localparam int STAT_RSVD_BIT = 7;
	localparam int STAT_RAW_LSB = 8;
	localparam int STAT_RAW_MSB = 17;
	localparam int STAT_DONE_BIT = 31;

endpackage

// ===== rtl/strap_sync.sv
// Two-stage synchroniser for a bundle of slow pin levels.
// The stages carry no reset on purpose: they must keep sampling the pins
// while the chip reset is held, so the value is settled at release.
module strap_sync #(
	parameter int WIDTH = 1
) (
	input wire logic sys_clk,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q; // First stage, read only by the second.

	// Shift the pin levels through both stages every cycle.
	always_ff @(posedge sys_clk) begin
		meta_q <= async_in;
		sync_out <= meta_q;
	end

endmodule

// ===== verification/strap_board.sv
// Board side of the strap pins: a pull per pin and the MAC inputs behind it.
module strap_board (
	input strap_pkg::strap_t pull,
	input strap_pkg::strap_t strap_oe,
	input strap_pkg::strap_t strap_out,
	output strap_pkg::strap_t pin
);
	timeunit 1ns;
	timeprecision 1ns;

	// A released pin settles to its pull, so a stale driven value never leaks.
	assign pin = (strap_oe & strap_out) | (~strap_oe & pull);
endmodule

// ===== verification/strap_option_latch_tb.sv
// Strap capture bench: table of strap patterns, then override and bus cases.
module strap_option_latch_tb;
	timeunit 1ns;
	timeprecision 1ns;

	// One row: strap pattern and the interface mode it should decode to.
	typedef struct packed {
		strap_pkg::strap_t s;
		strap_pkg::iface_mode_t m;
	} row_t;

	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	strap_pkg::strap_t pull = strap_pkg::STRAP_DEFAULT; // Board pull levels.
	strap_pkg::strap_t func_out = 10'h2aa; // Normal pin function values.
	strap_pkg::strap_t pin, strap_out, strap_oe, s;
	strap_pkg::wb_req_t wb_req = '0;
	strap_pkg::iface_mode_t iface_mode;
	logic wb_ack, speed_100, duplex_half, isolate, autoneg_enable, mode_reserved, straps_latched;
	logic [3:0] adv_caps;
	logic [4:0] station_address;
	logic [31:0] wb_dat_o, rd, ctrl_exp;
	int miscompares = 0;
	int checked = 0;
	row_t rows[8];

	// Half period of 25 ns gives the 20 MHz system clock.
	always #25 sys_clk = ~sys_clk;

	strap_board board (.pull(pull), .strap_oe(strap_oe), .strap_out(strap_out), .pin(pin));

	strap_option_latch dut (.sys_clk(sys_clk), .rstn(rstn), .strap_in(pin), .strap_out(strap_out),
		.strap_oe(strap_oe), .func_out(func_out), .wb_req(wb_req), .wb_ack(wb_ack),
		.wb_dat_o(wb_dat_o), .speed_100(speed_100), .duplex_half(duplex_half),
		.isolate(isolate), .autoneg_enable(autoneg_enable), .adv_caps(adv_caps),
		.iface_mode(iface_mode), .mode_reserved(mode_reserved),
		.station_address(station_address), .straps_latched(straps_latched));

	// Prints the counts and the verdict, then stops the run.
	task finish_test();
		$display("checks %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Case equality keeps an unknown from passing as a match.
	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// One classic Wishbone cycle. The request holds until the rising edge at which
	// ack is sampled high; read data is taken at that edge and the request is
	// released right after it, so cyc and stb stay low for a cycle before the next.
	task wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int n;
		@(posedge sys_clk);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: adr, dat: dat};
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (wb_ack !== 1'b1 && n < 20);
		if (wb_ack !== 1'b1) begin
			miscompares++;
			$display("mismatch at %0t: bus timeout", $time);
			finish_test();
		end
		rd = wb_dat_o;
		wb_req <= '0;
	endtask

	// Holds reset with the given pulls, then waits until the pins turn round.
	task apply(input strap_pkg::strap_t p);
		@(posedge sys_clk);
		pull <= p;
		rstn <= 1'b0;
		repeat (5) @(posedge sys_clk);
		chk(strap_oe, 10'h000, "oe in reset");
		chk({speed_100, duplex_half, isolate, autoneg_enable}, 4'hd, "defaults");
		chk(station_address, 5'h01, "addr default");
		rstn <= 1'b1;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask

	initial begin
		rows[0] = {10'b1110000001, strap_pkg::MODE_MII};
		rows[1] = {10'b0001001111, strap_pkg::MODE_RMII};
		rows[2] = {10'b1010010010, strap_pkg::MODE_RESERVED};
		rows[3] = {10'b0101011100, strap_pkg::MODE_RESERVED};
		rows[4] = {10'b1100100011, strap_pkg::MODE_MII100_PRE};
		rows[5] = {10'b0011101110, strap_pkg::MODE_RESERVED};
		rows[6] = {10'b1000110101, strap_pkg::MODE_RESERVED};
		rows[7] = {10'b0110111000, strap_pkg::MODE_RESERVED};
		// Every interface code once; the other straps vary from row to row.
		for (int i = 0; i < 8; i++) begin
			s = rows[i].s;
			apply(s);
			chk(iface_mode, rows[i].m, "mode");
			chk(mode_reserved, rows[i].m == strap_pkg::MODE_RESERVED, "rsvd");
			chk(speed_100, s.speed, "speed");
			chk(duplex_half, s.duplex, "duplex");
			chk(isolate, s.isolate, "isolate");
			chk(autoneg_enable, s.autoneg, "autoneg");
			chk(adv_caps, s.speed ? 4'hf : 4'h3, "adv");
			chk(station_address, {2'h0, s.addr}, "addr");
			chk(straps_latched, 1'b1, "latched");
			chk(strap_oe, 10'h3ff, "oe run");
			chk(strap_out, func_out, "pin out");
			ctrl_exp = 32'(s.speed) << strap_pkg::CTRL_SPEED_BIT;
			ctrl_exp |= 32'(s.autoneg) << strap_pkg::CTRL_AUTONEG_BIT;
			ctrl_exp |= 32'(s.isolate) << strap_pkg::CTRL_ISO_BIT;
			ctrl_exp |= 32'(s.duplex) << strap_pkg::CTRL_DUPLEX_BIT;
			wb(1'b0, strap_pkg::ADDR_CTRL, 32'h0);
			chk(rd & 32'h3500, ctrl_exp, "ctrl reg");
			wb(1'b0, strap_pkg::ADDR_ADV, 32'h0);
			chk(rd[8:5], s.speed ? 4'hf : 4'h3, "adv reg");
			wb(1'b0, strap_pkg::ADDR_STATUS, 32'h0);
			chk(rd, {1'b1, 13'h0, s, rows[i].m == strap_pkg::MODE_RESERVED, rows[i].m,
				2'h0, s.addr}, "status");
			$display("test row %0d done", i);
		end
		// Software override after capture; row 7 is still in force.
		wb(1'b1, strap_pkg::ADDR_CTRL, 32'h1400);
		chk({speed_100, duplex_half, isolate, autoneg_enable}, 4'h3, "override");
		// Advertisement override through both byte lanes: bits 8 and 5 set.
		wb(1'b1, strap_pkg::ADDR_ADV, 32'h120);
		chk(adv_caps, 4'h9, "adv override");
		wb(1'b0, strap_pkg::ADDR_ADV, 32'h0);
		chk(rd[8:5], 4'h9, "adv override reg");
		$display("test override done");
		// Pins now driven by the device; new levels on them must not recapture.
		func_out <= 10'h155;
		repeat (3) @(posedge sys_clk);
		chk(strap_out, 10'h155, "pin follow");
		chk(station_address, 5'h00, "addr held");
		wb(1'b0, strap_pkg::ADDR_STATUS, 32'h0);
		chk(rd[17:8], rows[7].s, "raw held");
		$display("test recapture done");
		// Unmapped place reads zero; the status register ignores writes.
		wb(1'b1, 8'h0c, 32'hffffffff);
		wb(1'b0, 8'h0c, 32'h0);
		chk(rd, 32'h0, "unmapped");
		wb(1'b1, strap_pkg::ADDR_STATUS, 32'h0);
		wb(1'b0, strap_pkg::ADDR_STATUS, 32'h0);
		chk(rd[31], 1'b1, "status ro");
		$display("test bus done");
		finish_test();
	end
endmodule
